// *** pkg/lpwc_pkg.sv ***
package lpwc_pkg;

   // -------------------------------------------------------------
   // widths
   // -------------------------------------------------------------
   localparam int unsigned NUM_WAKE = 40;
   localparam int unsigned NUM_TMR = 4;
   localparam int unsigned NUM_GPREG = 5;
   localparam int unsigned GPREG_W = 32;
   localparam int unsigned TMR_W = 16;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 50;
   // regulator ramp until the power-on trip point, in ns
   localparam int unsigned REG_RAMP_NS = 2000;
   localparam int unsigned REG_RAMP_CYC = (REG_RAMP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RAMP_W = 8;
   // wake latency, in core clocks, with the slow oscillator running and with the rc oscillator
   localparam logic [RAMP_W-1:0] SLOW_WAKE_CYC = 8'h40;
   localparam logic [RAMP_W-1:0] FAST_WAKE_CYC = 8'h02;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [NUM_WAKE-1:0] WAKE_RST = 40'h00_0000_0000;
   localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
   localparam logic [GPREG_W-1:0] GPREG_RST = 32'h0000_0000;

   // match output action
   typedef enum logic [1:0] {
      LPWC_MAT_NONE = 2'h0,
      LPWC_MAT_LOW = 2'h1,
      LPWC_MAT_HIGH = 2'h2,
      LPWC_MAT_TOGGLE = 2'h3
   } lpwc_mat_t;

   // power states, gray along run -> sleep -> wake -> dpd -> ramp
   typedef enum logic [2:0] {
      LPWC_RUN = 3'h0,
      LPWC_DSLEEP = 3'h1,
      LPWC_WAKE = 3'h3,
      LPWC_DPD = 3'h2,
      LPWC_RAMP = 3'h6
   } lpwc_state_t;

endpackage

// *** rtl/lpwc_top.sv ***
`timescale 1ns/1ps

// Operation
// [RQ1] pins port0 0..11 and port1 0 are selectable wake inputs
// [RQ2] edges latched without a clock; interrupt raised when enabled; code samples the pins on core_clk through sync flops
// [RQ3] deep-sleep ends when the wake logic interrupts the core
// [RQ4] software programs edge polarity and enables the interrupt per input
// [RQ5] interrupts 0..39 map one-to-one onto the 40 wake pins; code maps 36..39 to the timer match outputs instead
// [RQ6] software clears latched wake signals before use
// [RQ7] wake logic also gives vectored interrupts in run mode
// [RQ8] timer wake needs pin enable, timer clock and watchdog oscillator
// [RQ9] deep-sleep timer counts slow clocks; on match drives high, low or toggle
// [RQ10] match outputs are monitored as wake inputs; configured edge wakes
// [RQ11] brown-out wake needs detector powered and its reset enabled
// [RQ12] watchdog wake needs oscillator running and watchdog clock enabled
// [RQ13] wake latency with slow oscillator is longer than with rc oscillator
// [RQ14] deep-sleep entry: clear powerdown enable, set deepsleep bit, then wait
// [RQ15] deep power-down keeps only wake pin and general registers
// [RQ16] in deep power-down pins tri-state and reset pin is ignored
// [RQ17] deep power-down entry needs wake pin high, enable bit, deepsleep, wait; code enters without checking the wake pin
// [RQ18] rc oscillator and its output stay powered before deep power-down
// [RQ19] wake pin falling edge ends deep power-down with ramp then full reset
// [RQ20] after that wake only general registers and power control survive
// [RQ21] a flag tells deep power-down wake from cold reset; software clears it
// [RQ22] software should run from rc oscillator before deep-sleep
// [RQ23] each edge detector holds its event until software clears it
// [RQ24] flag set by hardware on entry, kept through reset until cleared
module lpwc_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cold_por,
   // wake pins, port0 0..11 at bits 0..11, port1 0 at bit 12, rest above
   input wire logic [lpwc_pkg::NUM_WAKE-1:0] wake_pins,
   // wake configuration
   input wire logic [lpwc_pkg::NUM_WAKE-1:0] wake_enable,
   input wire logic [lpwc_pkg::NUM_WAKE-1:0] wake_rising,
   input wire logic [lpwc_pkg::NUM_WAKE-1:0] wake_clear,
   input wire logic [lpwc_pkg::NUM_WAKE-1:0] nested_irq_enable,
   // timers
   input wire logic [lpwc_pkg::NUM_TMR-1:0] tmr_run,
   input wire logic [lpwc_pkg::NUM_TMR-1:0] tmr_clk_en,
   input wire logic [lpwc_pkg::NUM_TMR*lpwc_pkg::TMR_W-1:0] tmr_match,
   input wire logic [lpwc_pkg::NUM_TMR*2-1:0] tmr_action,
   input wire logic wdosc_tick,
   input wire logic wdosc_in_deepsleep,
   // power control
   input wire logic deep_powerdown_enable,
   input wire logic core_deepsleep_bit,
   input wire logic wait_for_interrupt_instr,
   input wire logic dpd_flag_clear,
   input wire logic brownout_reset_req,
   input wire logic watchdog_reset_req,
   input wire logic powerdown_wake_pin,
   input wire logic ext_reset_pin,
   // retained registers
   input wire logic gpreg_we,
   input wire logic [2:0] gpreg_sel,
   input wire logic [lpwc_pkg::GPREG_W-1:0] gpreg_wdata,
   // outputs
   output logic [lpwc_pkg::NUM_WAKE-1:0] wake_status,
   output logic [lpwc_pkg::NUM_WAKE-1:0] wake_irq,
   output logic [lpwc_pkg::NUM_TMR-1:0] tmr_mat_out,
   output logic in_deepsleep,
   output logic in_dpd,
   output logic pins_tristate,
   output logic sys_reset,
   output logic dpd_flag,
   output logic [lpwc_pkg::NUM_GPREG*lpwc_pkg::GPREG_W-1:0] gpreg_out
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [lpwc_pkg::NUM_WAKE-1:0] pin_s1;
      logic [lpwc_pkg::NUM_WAKE-1:0] pin_s2;
      logic [lpwc_pkg::NUM_WAKE-1:0] pin_prev;
      logic [lpwc_pkg::NUM_WAKE-1:0] latched;
      logic [lpwc_pkg::NUM_WAKE-1:0] irq;
      logic [lpwc_pkg::NUM_TMR*lpwc_pkg::TMR_W-1:0] tcnt;
      logic [lpwc_pkg::NUM_TMR-1:0] mat;
      logic wk_s1;
      logic wk_s2;
      logic rs_s1;
      logic rs_s2;
      logic wk_prev;
      logic [2:0] sync_ok;
      lpwc_pkg::lpwc_state_t st;
      logic [lpwc_pkg::RAMP_W-1:0] cnt;
      logic sysrst;
      logic sleep_o;
      logic dpd_o;
      logic flag;
      logic [lpwc_pkg::NUM_GPREG*lpwc_pkg::GPREG_W-1:0] gp;
   } lpwc_regs_t;

   lpwc_regs_t r;
   lpwc_regs_t next_r;

   // match outputs replace the upper wake input bits so they are monitored
   logic [lpwc_pkg::NUM_WAKE-1:0] wake_src;
   logic [lpwc_pkg::NUM_WAKE-1:0] edge_hit;
   logic [lpwc_pkg::NUM_TMR-1:0] mat_hit;
   logic any_irq;
   logic asleep;

   // ----------------------------------------------------------------
   // per-input edge detect and per-timer match
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < lpwc_pkg::NUM_WAKE; gi++) begin : g_wake
         if (gi >= lpwc_pkg::NUM_WAKE - lpwc_pkg::NUM_TMR) begin : g_mat
            assign wake_src[gi] = r.mat[gi - (lpwc_pkg::NUM_WAKE - lpwc_pkg::NUM_TMR)]; // RQ10
         end else begin : g_pin
            assign wake_src[gi] = r.pin_s2[gi]; // RQ1
         end
         // polarity selects which transition counts as an event
         // no edges until the sync and history flops hold real pin levels
         assign edge_hit[gi] = (&r.sync_ok) && wake_enable[gi] &&
            (wake_rising[gi] ? (wake_src[gi] && !r.pin_prev[gi])
                             : (!wake_src[gi] && r.pin_prev[gi])); // RQ2
      end
      for (gi = 0; gi < lpwc_pkg::NUM_TMR; gi++) begin : g_tmr
         assign mat_hit[gi] = tmr_run[gi] && tmr_clk_en[gi] && wdosc_tick &&
            (r.tcnt[gi*lpwc_pkg::TMR_W +: lpwc_pkg::TMR_W] ==
             tmr_match[gi*lpwc_pkg::TMR_W +: lpwc_pkg::TMR_W]); // RQ9
      end
   endgenerate

   assign any_irq = |r.irq;
   assign asleep = (r.st == lpwc_pkg::LPWC_DSLEEP);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.pin_s1 = wake_pins;
      next_r.pin_s2 = r.pin_s1;
      next_r.pin_prev = wake_src;
      next_r.wk_s1 = powerdown_wake_pin;
      next_r.wk_s2 = r.wk_s1;
      next_r.wk_prev = r.wk_s2;
      next_r.rs_s1 = ext_reset_pin;
      next_r.rs_s2 = r.rs_s1;
      // a reset empties the sync flops, which would fake an edge on a high pin
      next_r.sync_ok = (r.sync_ok << 1) | 3'h1;
      next_r.sysrst = 1'b0;
      // latched events hold until cleared; a new edge beats the clear
      next_r.latched = (r.latched & ~wake_clear) | edge_hit; // RQ23
      next_r.irq = next_r.latched & nested_irq_enable; // RQ5 RQ7
      // timers only advance on slow-oscillator ticks
      for (int t = 0; t < lpwc_pkg::NUM_TMR; t++) begin
         if (mat_hit[t]) begin
            next_r.tcnt[t*lpwc_pkg::TMR_W +: lpwc_pkg::TMR_W] = lpwc_pkg::TMR_RST;
            case (lpwc_pkg::lpwc_mat_t'(tmr_action[t*2 +: 2]))
               lpwc_pkg::LPWC_MAT_LOW: next_r.mat[t] = 1'b0;
               lpwc_pkg::LPWC_MAT_HIGH: next_r.mat[t] = 1'b1;
               lpwc_pkg::LPWC_MAT_TOGGLE: next_r.mat[t] = !r.mat[t];
               default: next_r.mat[t] = r.mat[t];
            endcase // RQ9
         end else if (tmr_run[t] && tmr_clk_en[t] && wdosc_tick) begin
            next_r.tcnt[t*lpwc_pkg::TMR_W +: lpwc_pkg::TMR_W] =
               r.tcnt[t*lpwc_pkg::TMR_W +: lpwc_pkg::TMR_W] + 16'h0001;
         end
      end
      if (gpreg_we && gpreg_sel < 3'(lpwc_pkg::NUM_GPREG) && r.st == lpwc_pkg::LPWC_RUN) begin
         next_r.gp[gpreg_sel*lpwc_pkg::GPREG_W +: lpwc_pkg::GPREG_W] = gpreg_wdata;
      end
      // software clear loses to a same-cycle entry
      if (dpd_flag_clear) begin
         next_r.flag = 1'b0; // RQ21
      end
      case (r.st)
         lpwc_pkg::LPWC_RUN: begin
            if (wait_for_interrupt_instr && core_deepsleep_bit) begin
               if (deep_powerdown_enable) begin
                  next_r.st = lpwc_pkg::LPWC_DPD; // RQ15
                  next_r.flag = 1'b1; // RQ24
               end else begin
                  next_r.st = lpwc_pkg::LPWC_DSLEEP;
               end
            end
         end
         lpwc_pkg::LPWC_DSLEEP: begin
            if (brownout_reset_req || watchdog_reset_req) begin
               next_r.st = lpwc_pkg::LPWC_RUN;
               next_r.sysrst = 1'b1;
            end else if (any_irq) begin
               next_r.st = lpwc_pkg::LPWC_WAKE; // RQ3
               next_r.cnt = wdosc_in_deepsleep ? lpwc_pkg::SLOW_WAKE_CYC
                                               : lpwc_pkg::FAST_WAKE_CYC; // RQ13
            end
         end
         lpwc_pkg::LPWC_WAKE: begin
            next_r.cnt = r.cnt - 8'h01;
            if (r.cnt <= 8'h01) begin
               next_r.st = lpwc_pkg::LPWC_RUN;
            end
         end
         lpwc_pkg::LPWC_DPD: begin
            // only a falling edge of the wake pin ends it; reset pin ignored
            next_r.latched = lpwc_pkg::WAKE_RST; // RQ16
            next_r.irq = lpwc_pkg::WAKE_RST;
            if (r.wk_prev && !r.wk_s2) begin
               next_r.st = lpwc_pkg::LPWC_RAMP; // RQ19
               next_r.cnt = lpwc_pkg::RAMP_W'(lpwc_pkg::REG_RAMP_CYC);
            end
         end
         lpwc_pkg::LPWC_RAMP: begin
            next_r.cnt = r.cnt - 8'h01;
            next_r.latched = lpwc_pkg::WAKE_RST;
            next_r.irq = lpwc_pkg::WAKE_RST;
            if (r.cnt <= 8'h01) begin
               next_r.st = lpwc_pkg::LPWC_RUN;
               next_r.sysrst = 1'b1; // RQ19
            end
         end
         default: next_r.st = lpwc_pkg::LPWC_RUN;
      endcase
      // reset pin works everywhere but deep power-down and its ramp
      if (r.rs_s2 && r.st != lpwc_pkg::LPWC_DPD && r.st != lpwc_pkg::LPWC_RAMP) begin
         next_r.sysrst = 1'b1; // RQ16
      end
      // the wake-up reset clears events, interrupts, timers, match outputs and state; retained data, flag, sync flops and counter stay
      if (r.sysrst) begin
         next_r.latched = lpwc_pkg::WAKE_RST; // RQ20
         next_r.irq = lpwc_pkg::WAKE_RST;
         next_r.tcnt = '0;
         next_r.mat = '0;
         next_r.st = lpwc_pkg::LPWC_RUN;
      end
      // flopped copies of the power state so the status pins never glitch
      next_r.sleep_o = (next_r.st == lpwc_pkg::LPWC_DSLEEP) ||
         (next_r.st == lpwc_pkg::LPWC_WAKE); // RQ13
      next_r.dpd_o = (next_r.st == lpwc_pkg::LPWC_DPD) ||
         (next_r.st == lpwc_pkg::LPWC_RAMP); // RQ16
   end

   // ----------------------------------------------------------------
   // registers; rst is a system reset that spares retained state,
   // cold_por wipes everything including the flag
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (cold_por) begin
         r <= '0;
      end else if (rst) begin
         r <= '0;
         r.gp <= r.gp; // RQ20
         r.flag <= r.flag; // RQ24
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flops
   // ----------------------------------------------------------------
   assign wake_status = r.latched;
   assign wake_irq = r.irq;
   assign tmr_mat_out = r.mat;
   assign in_deepsleep = r.sleep_o;
   assign in_dpd = r.dpd_o;
   assign pins_tristate = r.dpd_o; // RQ16
   assign sys_reset = r.sysrst;
   assign dpd_flag = r.flag; // RQ21
   assign gpreg_out = r.gp; // RQ15

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_latch_holds: assert property (@(posedge core_clk) disable iff (rst || cold_por) // RQ23
      r.latched[0] && !wake_clear[0] && !r.dpd_o && !r.sysrst |=> r.latched[0])
      else $error("wake latch dropped without clear");
   chk_irq_gate: assert property (@(posedge core_clk) disable iff (rst || cold_por) // RQ5
      r.irq[0] == (r.latched[0] && $past(nested_irq_enable[0])))
      else $error("irq does not follow latched event and enable");
   chk_sleep_exit: assert property (@(posedge core_clk) disable iff (rst || cold_por) // RQ3
      asleep && any_irq && !brownout_reset_req && !watchdog_reset_req && !r.sysrst
      |=> r.st == lpwc_pkg::LPWC_WAKE)
      else $error("deep-sleep not left on interrupt");
   chk_dpd_flag: assert property (@(posedge core_clk) disable iff (rst || cold_por) // RQ24
      r.st == lpwc_pkg::LPWC_RUN && wait_for_interrupt_instr && core_deepsleep_bit &&
      deep_powerdown_enable && !r.sysrst |=> r.flag && in_dpd)
      else $error("flag not set on deep power-down entry");
   chk_dpd_tristate: assert property (@(posedge core_clk) disable iff (rst || cold_por) // RQ16
      r.st == lpwc_pkg::LPWC_DPD |-> pins_tristate && !r.sysrst)
      else $error("pins driven or reset in deep power-down");
   chk_dpd_wake: assert property (@(posedge core_clk) disable iff (rst || cold_por) // RQ19
      r.st == lpwc_pkg::LPWC_DPD && r.wk_prev && !r.wk_s2 && !r.sysrst
      |=> r.st == lpwc_pkg::LPWC_RAMP)
      else $error("deep power-down not left on wake pin fall");
   chk_ramp_reset: assert property (@(posedge core_clk) disable iff (rst || cold_por) // RQ19
      r.st == lpwc_pkg::LPWC_RAMP && r.cnt == 8'h01 |=> r.sysrst)
      else $error("no reset after regulator ramp");
   chk_match_high: assert property (@(posedge core_clk) disable iff (rst || cold_por) // RQ9
      mat_hit[0] && tmr_action[1:0] == lpwc_pkg::LPWC_MAT_HIGH && !r.sysrst |=> r.mat[0])
      else $error("match output not driven high");
   chk_wake_slow: assert property (@(posedge core_clk) disable iff (rst || cold_por) // RQ13
      asleep && any_irq && wdosc_in_deepsleep && !brownout_reset_req &&
      !watchdog_reset_req && !r.rs_s2 |=> r.cnt == lpwc_pkg::SLOW_WAKE_CYC)
      else $error("slow wake latency not loaded");

endmodule

// *** testbench/lpwc_pin_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// board side: wake pins and the dedicated wake line
// ----------------------------------------
module lpwc_pin_model (
   // clock
   input wire logic core_clk,
   // pins
   output logic [lpwc_pkg::NUM_WAKE-1:0] wake_pins,
   output logic powerdown_wake_pin
);
   // wake line pulled high while idle so a later falling edge can end power-down
   initial begin
      wake_pins = '0;
      powerdown_wake_pin = 1'b1;
   end

   // pins change just after an edge, like a board driven off the same clock
   task automatic set_pin(input int idx, input logic lvl);
      @(posedge core_clk);
      wake_pins[idx] <= lvl;
   endtask

   task automatic set_wake(input logic lvl);
      @(posedge core_clk);
      powerdown_wake_pin <= lvl;
   endtask
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps

module testbench;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam int NW = lpwc_pkg::NUM_WAKE;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic cold_por = 1'b1;
   logic [NW-1:0] wake_pins, wake_enable = '0, wake_rising = '0, wake_clear = '0;
   logic [NW-1:0] nested_irq_enable = '0, wake_status, wake_irq;
   logic [3:0] tmr_run = '0, tmr_clk_en = '0, tmr_mat_out;
   logic [63:0] tmr_match = '0;
   logic [7:0] tmr_action = '0;
   logic wdosc_tick = 1'b0, wdosc_in_deepsleep = 1'b0, tick_on = 1'b0;
   logic deep_powerdown_enable = 1'b0, core_deepsleep_bit = 1'b0;
   logic wait_for_interrupt_instr = 1'b0, dpd_flag_clear = 1'b0;
   logic brownout_reset_req = 1'b0, watchdog_reset_req = 1'b0;
   logic powerdown_wake_pin, ext_reset_pin = 1'b0, gpreg_we = 1'b0;
   logic [2:0] gpreg_sel = '0;
   logic [31:0] gpreg_wdata = '0;
   logic in_deepsleep, in_dpd, pins_tristate, sys_reset, dpd_flag;
   logic [159:0] gpreg_out;
   int bad_count = 0;
   int checks = 0;
   int n, n_rc, b;
   int bits[4] = '{0, 11, 12, 20};

   always #10 core_clk = ~core_clk;
   // slow oscillator ticks every other core clock only when asked for
   always @(posedge core_clk) wdosc_tick <= tick_on & ~wdosc_tick;

   lpwc_pin_model pm (.core_clk(core_clk), .wake_pins(wake_pins),
      .powerdown_wake_pin(powerdown_wake_pin));

   lpwc_top dut (.core_clk(core_clk), .rst(rst), .cold_por(cold_por), .wake_pins(wake_pins),
      .wake_enable(wake_enable), .wake_rising(wake_rising), .wake_clear(wake_clear),
      .nested_irq_enable(nested_irq_enable), .tmr_run(tmr_run), .tmr_clk_en(tmr_clk_en),
      .tmr_match(tmr_match), .tmr_action(tmr_action), .wdosc_tick(wdosc_tick),
      .wdosc_in_deepsleep(wdosc_in_deepsleep), .deep_powerdown_enable(deep_powerdown_enable),
      .core_deepsleep_bit(core_deepsleep_bit),
      .wait_for_interrupt_instr(wait_for_interrupt_instr), .dpd_flag_clear(dpd_flag_clear),
      .brownout_reset_req(brownout_reset_req), .watchdog_reset_req(watchdog_reset_req),
      .powerdown_wake_pin(powerdown_wake_pin), .ext_reset_pin(ext_reset_pin),
      .gpreg_we(gpreg_we), .gpreg_sel(gpreg_sel), .gpreg_wdata(gpreg_wdata),
      .wake_status(wake_status), .wake_irq(wake_irq), .tmr_mat_out(tmr_mat_out),
      .in_deepsleep(in_deepsleep), .in_dpd(in_dpd), .pins_tristate(pins_tristate),
      .sys_reset(sys_reset), .dpd_flag(dpd_flag), .gpreg_out(gpreg_out));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // latched events would otherwise survive from earlier traffic
   task automatic clear_all();
      @(posedge core_clk) wake_clear <= '1;
      @(posedge core_clk) wake_clear <= '0;
   endtask

   // enable bit set first, then the core bit, then the wait instruction
   task automatic enter_sleep(input logic dpd);
      @(posedge core_clk) deep_powerdown_enable <= dpd;
      @(posedge core_clk) core_deepsleep_bit <= 1'b1;
      @(posedge core_clk) wait_for_interrupt_instr <= 1'b1;
      @(posedge core_clk) wait_for_interrupt_instr <= 1'b0;
      #1 check("in_deepsleep", in_deepsleep | in_dpd, 1);
   endtask

   // bounded wait for deep-sleep to end, counting cycles
   task automatic wake_time(output int cnt);
      cnt = 0;
      while (in_deepsleep === 1'b1 && cnt < 500) begin
         @(posedge core_clk) #1;
         cnt++;
      end
      #1 check("sleep_left", in_deepsleep, 0);
   endtask

   task automatic arm(input int i, input logic rise);
      @(posedge core_clk);
      wake_enable[i] <= 1'b1;
      wake_rising[i] <= rise;
      nested_irq_enable[i] <= 1'b1;
   endtask

   task automatic wait_reset_pulse(output int cnt);
      cnt = 0;
      while (sys_reset !== 1'b1 && cnt < 400) begin
         @(posedge core_clk) #1;
         cnt++;
      end
      check("sys_reset", sys_reset, 1);
   endtask

   // ----------------------------------------
   // watchdog against a hang
   // ----------------------------------------
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      end_of_test();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      cold_por <= 1'b0;
      @(posedge core_clk) #1;
      check("reset_state", {wake_status, in_dpd, dpd_flag}, '0);
      // run mode edges of both polarities, latched until cleared
      foreach (bits[k]) begin
         b = bits[k];
         arm(b, k % 2 == 0);
         pm.set_pin(b, k % 2 != 0);
         repeat (4) @(posedge core_clk);
         clear_all();
         pm.set_pin(b, k % 2 == 0);
         repeat (3) @(posedge core_clk);
         #1 check("wake_status", wake_status, 64'(1) << b);
         check("wake_irq", wake_irq, 64'(1) << b);
         pm.set_pin(b, k % 2 != 0);
         repeat (5) @(posedge core_clk);
         #1 check("wake_held", wake_status[b], 1);
         clear_all();
         @(posedge core_clk) #1 check("wake_cleared", wake_status, 0);
      end
      // deep-sleep latency, rc then slow oscillator
      arm(5, 1'b1);
      for (int s = 0; s < 2; s++) begin
         pm.set_pin(5, 1'b0);
         wdosc_in_deepsleep <= s[0];
         repeat (4) @(posedge core_clk);
         clear_all();
         enter_sleep(1'b0);
         pm.set_pin(5, 1'b1);
         if (s == 0) wake_time(n_rc);
         else wake_time(n);
      end
      check("slow_extra", 64'(n - n_rc),
         64'(lpwc_pkg::SLOW_WAKE_CYC - lpwc_pkg::FAST_WAKE_CYC));
      // timer 0 match drives its output high and wakes through input 36
      @(posedge core_clk);
      tmr_action[1:0] <= 2'h2;
      tmr_match[15:0] <= 16'h0003;
      tmr_clk_en[0] <= 1'b1;
      arm(36, 1'b1);
      clear_all();
      enter_sleep(1'b0);
      @(posedge core_clk);
      tmr_run[0] <= 1'b1;
      tick_on <= 1'b1;
      wake_time(n);
      check("match_out", tmr_mat_out[0], 1);
      check("match_wake", wake_status[36], 1);
      @(posedge core_clk);
      tmr_run[0] <= 1'b0;
      tick_on <= 1'b0;
      // brown-out and watchdog resets end deep-sleep
      for (int r = 0; r < 2; r++) begin
         clear_all();
         enter_sleep(1'b0);
         @(posedge core_clk);
         brownout_reset_req <= (r == 0);
         watchdog_reset_req <= (r == 1);
         wait_reset_pulse(n);
         check("reset_woke", in_deepsleep, 0);
         @(posedge core_clk);
         brownout_reset_req <= 1'b0;
         watchdog_reset_req <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
      // deep power-down with retained registers
      clear_all();
      @(posedge core_clk) gpreg_we <= 1'b1;
      gpreg_wdata <= 32'ha5c3_0f96;
      @(posedge core_clk) gpreg_sel <= 3'h4;
      gpreg_wdata <= 32'h1234_5678;
      @(posedge core_clk) gpreg_we <= 1'b0;
      // the rc oscillator stays powered; nothing in this block gates it
      enter_sleep(1'b1);
      @(posedge core_clk) #1 check("dpd", {in_dpd, pins_tristate, dpd_flag}, 3'b111);
      @(posedge core_clk) ext_reset_pin <= 1'b1;
      pm.set_pin(0, 1'b0);
      pm.set_pin(0, 1'b1);
      repeat (6) @(posedge core_clk);
      ext_reset_pin <= 1'b0;
      #1 check("dpd_ignores", {in_dpd, sys_reset, wake_status[0]}, 3'b100);
      pm.set_wake(1'b0);
      deep_powerdown_enable <= 1'b0;
      core_deepsleep_bit <= 1'b0;
      wait_reset_pulse(n);
      check("ramp", n >= lpwc_pkg::REG_RAMP_CYC, 1);
      pm.set_wake(1'b1);
      @(posedge core_clk) #1 check("dpd_left", in_dpd, 0);
      check("flag_kept", dpd_flag, 1);
      check("gp0", gpreg_out[31:0], 32'ha5c3_0f96);
      @(posedge core_clk) rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk) #1 check("gp4", gpreg_out[159:128], 32'h1234_5678);
      check("flag_rst", dpd_flag, 1);
      @(posedge core_clk) dpd_flag_clear <= 1'b1;
      @(posedge core_clk) dpd_flag_clear <= 1'b0;
      @(posedge core_clk) #1 check("flag_clr", dpd_flag, 0);
      @(posedge core_clk) cold_por <= 1'b1;
      @(posedge core_clk) cold_por <= 1'b0;
      @(posedge core_clk) #1 check("cold", {dpd_flag, |gpreg_out}, 0);
      end_of_test();
   end
endmodule
